//--- logic/signal_monitor_status_regs.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module signal_monitor_status_regs
  import monitor_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // monitor inputs from the same clock domain
  input wire logic [RESULT_W-1:0] peak_result,
  input wire logic [PERIOD_W-1:0] monitor_period,
  // monitor serial port controls and result source select
  output logic monitor_serial_port_enable,
  output logic [INSEL_W-1:0] monitor_serial_port_input_sel,
  output logic [SEL_W-1:0] result_select
);
  // write channel state
  logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
  logic [IDX_W-1:0] waddr_q, waddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wlane_q, wlane_d;
  logic [1:0] bresp_q, bresp_d;
  // read channel state
  logic rvalid_q, rvalid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // register state
  logic update_q, update_d;
  logic [SEL_W-1:0] sel_q, sel_d;
  logic [RESULT_W-1:0] result_q, result_d;
  logic [FRAME_W-1:0] frame_q, frame_d;
  logic link_en_q, link_en_d, link_rsv_q, link_rsv_d;
  logic [INSEL_W-1:0] insel_q, insel_d;
  // helpers
  logic do_write, expire;
  logic [IDX_W-1:0] ridx;
  logic [RESULT_W-1:0] source;
  logic write_hit, read_hit;
  logic [7:0] read_byte;

  monitor_period_timer #(.WIDTH(PERIOD_W)) period_timer (
    .clk(clk),
    .rst_n(rst_n),
    .period(monitor_period),
    .expire(expire)
  );

  // handshake outputs
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign monitor_serial_port_enable = link_en_q;
  assign monitor_serial_port_input_sel = insel_q;
  assign result_select = sel_q;

  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign ridx = s_axi_araddr[ADDR_W-1:2];

  // source selection for the readback path
  always_comb begin
    source = RESULT_RESET;
    if (sel_q == SEL_PEAK) begin
      source = peak_result;
    end
  end

  // write address decode
  always_comb begin
    unique case (waddr_q)
      IDX_STATUS_CTRL, IDX_RESULT_LOW, IDX_RESULT_MID, IDX_RESULT_HIGH,
      IDX_FRAME_COUNT, IDX_LINK_CTRL, IDX_LINK_INSEL: write_hit = 1'b1;
      default: write_hit = 1'b0;
    endcase
  end

  // read multiplexer
  always_comb begin
    read_hit = 1'b1;
    read_byte = 8'h00;
    unique case (ridx)
      IDX_STATUS_CTRL: begin
        read_byte[UPDATE_BIT] = update_q;
        read_byte[SEL_W-1:0] = sel_q;
      end
      IDX_RESULT_LOW: read_byte = result_q[7:0];
      IDX_RESULT_MID: read_byte = result_q[15:8];
      IDX_RESULT_HIGH: read_byte = {4'h0, result_q[RESULT_W-1:16]};
      IDX_FRAME_COUNT: read_byte = frame_q;
      IDX_LINK_CTRL: begin
        read_byte[LINK_EN_BIT] = link_en_q;
        read_byte[LINK_RSV_BIT] = link_rsv_q;
      end
      IDX_LINK_INSEL: read_byte[INSEL_W-1:0] = insel_q;
      default: read_hit = 1'b0;
    endcase
  end

  // bus channel next state
  always_comb begin
    aw_held_d = aw_held_q;
    waddr_d = waddr_q;
    w_held_d = w_held_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      waddr_d = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wlane_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, read_byte};
      rresp_d = read_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // register file next state
  always_comb begin
    sel_d = sel_q;
    link_en_d = link_en_q;
    link_rsv_d = link_rsv_q;
    insel_d = insel_q;
    // update bit clears itself one cycle after it is set
    update_d = 1'b0;
    result_d = result_q;
    if (update_q) begin
      result_d = source;
    end
    frame_d = expire ? frame_q + 1'b1 : frame_q;
    if (do_write && wlane_q) begin
      unique case (waddr_q)
        IDX_STATUS_CTRL: begin
          update_d = wbyte_q[UPDATE_BIT];
          sel_d = wbyte_q[SEL_W-1:0];
        end
        IDX_LINK_CTRL: begin
          link_en_d = wbyte_q[LINK_EN_BIT];
          link_rsv_d = wbyte_q[LINK_RSV_BIT];
        end
        IDX_LINK_INSEL: insel_d = wbyte_q[INSEL_W-1:0];
        default: ;
      endcase
    end
  end

  // bus channel registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      waddr_q <= '0;
      w_held_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      waddr_q <= waddr_d;
      w_held_q <= w_held_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // reset values of the register file
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      update_q <= 1'b0;
      sel_q <= SEL_RESET;
      result_q <= RESULT_RESET;
      frame_q <= FRAME_RESET;
      link_en_q <= 1'b0;
      link_rsv_q <= 1'b0;
      insel_q <= INSEL_RESET;
    end else begin
      update_q <= update_d;
      sel_q <= sel_d;
      result_q <= result_d;
      frame_q <= frame_d;
      link_en_q <= link_en_d;
      link_rsv_q <= link_rsv_d;
      insel_q <= insel_d;
    end
  end
endmodule // signal_monitor_status_regs

//--- include/monitor_status_pkg.sv
// shared constants for the signal monitor status registers
package monitor_status_pkg;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STATUS_CTRL = 10'h274;
  localparam logic [IDX_W-1:0] IDX_RESULT_LOW = 10'h275;
  localparam logic [IDX_W-1:0] IDX_RESULT_MID = 10'h276;
  localparam logic [IDX_W-1:0] IDX_RESULT_HIGH = 10'h277;
  localparam logic [IDX_W-1:0] IDX_FRAME_COUNT = 10'h278;
  localparam logic [IDX_W-1:0] IDX_LINK_CTRL = 10'h279;
  localparam logic [IDX_W-1:0] IDX_LINK_INSEL = 10'h27a;
  // field positions and widths
  localparam int UPDATE_BIT = 4;
  localparam int SEL_W = 3;
  localparam int RESULT_W = 20;
  localparam int FRAME_W = 8;
  localparam int LINK_EN_BIT = 0;
  localparam int LINK_RSV_BIT = 1;
  localparam int INSEL_W = 6;
  localparam int PERIOD_W = 24;
  // reset values and encodings
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h1;
  localparam logic [SEL_W-1:0] SEL_PEAK = 3'h1;
  localparam logic [INSEL_W-1:0] INSEL_RESET = 6'h02;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 20'h00000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/monitor_period_timer.sv
`timescale 1ns/10ps
// counts monitor period cycles and pulses once at each expiry
module monitor_period_timer
  import monitor_status_pkg::*;
#(
  parameter int WIDTH = PERIOD_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // period length in clock cycles, bit 0 ignored
  input wire logic [WIDTH-1:0] period,
  // one-cycle pulse at expiry
  output logic expire
);
  logic [WIDTH-1:0] count_q, count_d;
  logic [WIDTH-1:0] limit;

  // lsb dropped so the period is always even; zero stops the timer
  assign limit = {period[WIDTH-1:1], 1'b0};

  // next count and expiry
  always_comb begin
    count_d = count_q + 1'b1;
    expire = 1'b0;
    if (limit == '0) begin
      count_d = '0;
    end else if (count_q >= limit - 1'b1) begin
      count_d = '0;
      expire = 1'b1;
    end
  end

  // count register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule // monitor_period_timer

//--- test/monitor_status_chk.sv
`timescale 1ns/10ps
// bus timing and field update rules at the register bank ports
module monitor_status_chk
  import monitor_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  // register outputs
  input wire logic monitor_serial_port_enable,
  input wire logic [INSEL_W-1:0] monitor_serial_port_input_sel,
  input wire logic [SEL_W-1:0] result_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // address and data taken together, answer two edges on
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_wr_answer_time: assert property (wr_taken |=> wr_answer)
    else $error("write response not two cycles after accept");
  a_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_wr_no_accept: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write accepted early");
  a_rd_answer_time: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  a_rd_resp_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_rd_one_out: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_rd_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  a_field_on_write: assert property (
    $changed({monitor_serial_port_enable, monitor_serial_port_input_sel,
    result_select}) |-> $rose(s_axi_bvalid)) else $error("field changed alone");
endmodule // monitor_status_chk

bind signal_monitor_status_regs monitor_status_chk chk_i (
  .clk(clk),
  .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_rdata(s_axi_rdata),
  .monitor_serial_port_enable(monitor_serial_port_enable),
  .monitor_serial_port_input_sel(monitor_serial_port_input_sel),
  .result_select(result_select)
);

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
  import monitor_status_pkg::*;
  // design ports
  logic clk = 1'h0, rst_n = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, monitor_serial_port_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [RESULT_W-1:0] peak_result = '0;
  logic [PERIOD_W-1:0] monitor_period = '0;
  logic [INSEL_W-1:0] monitor_serial_port_input_sel;
  logic [SEL_W-1:0] result_select;
  logic [31:0] d;
  int bad_count = 0, checks = 0, cyc = 0, rc;
  signal_monitor_status_regs uut (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .peak_result(peak_result),
    .monitor_period(monitor_period),
    .monitor_serial_port_enable(monitor_serial_port_enable),
    .monitor_serial_port_input_sel(monitor_serial_port_input_sel),
    .result_select(result_select)
  );
  // clock, cycle count and hang limit
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  initial begin #200000; bad_count++; end_sim; end
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one write; handshakes judged at the falling edge before
  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    logic ta, tw, tk, done;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    done = 0;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tk = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tk) s_axi_bready <= 1'h0;
      done = tk;
    end
    if (!done) begin bad_count++; end_sim; end
  endtask
  // one read; rready held up with the request until data is shown
  // rc keeps the cycle count seen just before the accepting edge
  task automatic rd(input logic [9:0] i);
    logic ta, tk, done;
    @(posedge clk);
    s_axi_araddr <= {i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    done = 0;
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tk = s_axi_rvalid;
      if (ta) rc = cyc;
      {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tk) s_axi_rready <= 1'h0;
      done = tk;
    end
    if (!done) begin bad_count++; end_sim; end
  endtask
  task automatic rchk(input logic [9:0] i, input logic [31:0] e);
    rd(i);
    chk(d, e);
  endtask
  task automatic t_reset;
    logic [7:0] rv [7] = '{8'h01, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h02};
    for (int k = 0; k < 7; k++) rchk(10'(IDX_STATUS_CTRL + k), rv[k]);
    chk(result_select, SEL_RESET);
    chk(monitor_serial_port_input_sel, INSEL_RESET);
    chk(monitor_serial_port_enable, 1'h0);
  endtask
  task automatic t_update;
    @(posedge clk) peak_result <= 20'habcde;
    wr(IDX_STATUS_CTRL, 8'h11);
    peak_result <= 20'h12345;
    rchk(IDX_STATUS_CTRL, 32'h01);
    rchk(IDX_RESULT_LOW, 32'hde);
    rchk(IDX_RESULT_MID, 32'hbc);
    rchk(IDX_RESULT_HIGH, 32'h0a);
    wr(IDX_STATUS_CTRL, 8'h12);
    chk(result_select, 3'h2);
    rchk(IDX_RESULT_MID, 32'h0);
    wr(IDX_STATUS_CTRL, 8'h01);
  endtask
  task automatic t_refuse;
    wr(IDX_RESULT_HIGH, 8'hff);
    chk(r, RESP_OKAY);
    rchk(IDX_RESULT_HIGH, 32'h0);
    wr(10'h27b, 8'h01);
    chk(r, RESP_SLVERR);
    rchk(10'h27b, 32'h0);
    chk(r, RESP_SLVERR);
    @(posedge clk) s_axi_wstrb <= 4'h0;
    wr(IDX_LINK_CTRL, 8'h01);
    s_axi_wstrb <= 4'hf;
    chk(monitor_serial_port_enable, 1'h0);
  endtask
  task automatic t_link;
    wr(IDX_LINK_CTRL, 8'h03);
    chk(monitor_serial_port_enable, 1'h1);
    rchk(IDX_LINK_CTRL, 32'h03);
    wr(IDX_LINK_CTRL, 8'h02);
    chk(monitor_serial_port_enable, 1'h0);
    wr(IDX_LINK_INSEL, 8'hff);
    rchk(IDX_LINK_INSEL, 32'h3f);
    wr(IDX_LINK_INSEL, 8'h01);
    chk(monitor_serial_port_input_sel, 6'h01);
  endtask
  // period 9 acts as 8; the two reads are accepted 88 cycles apart
  task automatic t_frame;
    int c0, t0;
    @(posedge clk) monitor_period <= 24'h9;
    rd(IDX_FRAME_COUNT);
    {c0, t0} = {d, rc};
    for (int n = 0; n < 200 && cyc + 1 - t0 < 88; n++) @(negedge clk);
    rd(IDX_FRAME_COUNT);
    chk(8'(d - c0), 32'((rc - t0) / 8));
    monitor_period <= '0;
  endtask
  // main sequence with a second reset mid-run
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_reset;
    t_update;
    t_refuse;
    t_link;
    t_frame;
    @(posedge clk) rst_n <= 1'h0;
    @(posedge clk) rst_n <= 1'h1;
    t_reset;
    end_sim;
  end
endmodule // tb
